// File: src/rftfc_codec.sv
// rftfc_codec: request flags decoder and response flags builder with apb registers
// assumes: a demodulator delivers sof, eof and bits lsb first; a modulator takes tx bits on TX_READY
//
// The address map and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rftfc_codec #(
  parameter logic [7:0] CMD_SYSINFO = rftfc_pkg::CMD_SYSINFO_DEF
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // receive bit stream
  input  wire logic        RX_SOF,
  input  wire logic        RX_EOF,
  input  wire logic        RX_BIT_VALID,
  input  wire logic        RX_BIT,
  // transmit bit stream
  input  wire logic        TX_START,
  input  wire logic        TX_ERROR,
  input  wire logic        TX_READY,
  output logic             TX_BIT,
  output logic             TX_BIT_VALID,
  output logic             TX_DONE,
  // decoded request for the tag logic
  output logic             FRAME_VALID,
  output logic             RESP_DUAL_SUBCARRIER,
  output logic             RESP_HIGH_RATE,
  output logic             NEED_SELECTED,
  output logic             UID_PRESENT,
  output logic             AFI_PRESENT,
  output logic             SINGLE_SLOT,
  output logic             RICH_SYSINFO
);

  typedef struct packed {
    rftfc_pkg::rftfc_rx_type     rx;
    logic [7:0]                  shreg;
    logic [2:0]                  bitcnt;
    logic [7:0]                  bytecnt;
    logic [7:0]                  req;
    logic [7:0]                  cmd;
    rftfc_pkg::rftfc_decode_type dec;
    logic                        frame_valid;
    logic                        crc_err;
    logic                        conflict;
    logic                        rx_en;
    logic                        force_err;
    rftfc_pkg::rftfc_tx_type     tx;
    logic [7:0]                  resp;
    logic [7:0]                  txsh;
    logic [2:0]                  txcnt;
    logic                        tx_bit;
    logic                        tx_valid;
    logic                        tx_done;
    logic [31:0]                 prdata;
  } rftfc_codec_state_type;

  rftfc_codec_state_type state;
  rftfc_codec_state_type next_state;

  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic        rx_take;
  logic        tx_take;
  logic        tx_go;
  logic        apb_write;
  logic        apb_setup;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_status;
  logic [7:0]  rx_byte;
  logic [31:0] rd_data;

  // bus qualifiers; slave never stalls, so every access phase completes
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & PWRITE;
  assign mapped    = (PADDR == rftfc_pkg::OFF_CTRL)   | (PADDR == rftfc_pkg::OFF_STATUS) |
                     (PADDR == rftfc_pkg::OFF_REQ)    | (PADDR == rftfc_pkg::OFF_DECODE) |
                     (PADDR == rftfc_pkg::OFF_RESP)   | (PADDR == rftfc_pkg::OFF_CRC);
  assign wr_ctrl   = apb_write & (PADDR == rftfc_pkg::OFF_CTRL);
  assign wr_status = apb_write & (PADDR == rftfc_pkg::OFF_STATUS);

  // stream qualifiers
  assign rx_take = (state.rx == rftfc_pkg::RX_FRAME) & RX_BIT_VALID & ~RX_SOF & ~RX_EOF;
  assign tx_take = (state.tx == rftfc_pkg::TX_SEND) & state.tx_valid & TX_READY;
  assign tx_go   = (state.tx == rftfc_pkg::TX_IDLE) & (TX_START | (wr_ctrl & PWDATA[rftfc_pkg::CTRL_TX_GO]));
  // lsb first: newest bit enters at the top
  assign rx_byte = {RX_BIT, state.shreg[7:1]};

  // receive checksum: cleared to ones at each start of frame
  rftfc_crc16 u_rx_crc (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .clear    (RX_SOF),
    .enable   (rx_take),
    .data_bit (RX_BIT),
    .crc      (rx_crc)
  );

  // response checksum runs over the flags byte as it is sent
  rftfc_crc16 u_tx_crc (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .clear    (tx_go),
    .enable   (tx_take),
    .data_bit (state.tx_bit),
    .crc      (tx_crc)
  );

  // read mux, latched in the setup cycle so PRDATA stands as a flop in the access phase
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (PADDR)
      rftfc_pkg::OFF_CTRL: begin
        rd_data[rftfc_pkg::CTRL_RX_EN]     = state.rx_en;
        rd_data[rftfc_pkg::CTRL_FORCE_ERR] = state.force_err;
      end
      rftfc_pkg::OFF_STATUS: begin
        rd_data[rftfc_pkg::ST_FRAME_VALID] = state.frame_valid;
        rd_data[rftfc_pkg::ST_CRC_ERR]     = state.crc_err;
        rd_data[rftfc_pkg::ST_IN_FRAME]    = (state.rx == rftfc_pkg::RX_FRAME);
        rd_data[rftfc_pkg::ST_TX_BUSY]     = (state.tx == rftfc_pkg::TX_SEND);
        rd_data[rftfc_pkg::ST_CONFLICT]    = state.conflict;
        rd_data[rftfc_pkg::ST_BYTES_LSB +: 8] = state.bytecnt;
      end
      rftfc_pkg::OFF_REQ: begin
        rd_data[15:0] = {state.cmd, state.req};
      end
      rftfc_pkg::OFF_DECODE: begin
        rd_data[9:0] = {state.dec.rich_sysinfo, state.dec.single_slot, state.dec.afi_present,
                        state.dec.option, state.dec.uid_present, state.dec.need_selected,
                        state.dec.extension, state.dec.inventory, state.dec.high_rate,
                        state.dec.dual_sub};
        rd_data[rftfc_pkg::DEC_SLOTS_LSB +: 5] = state.dec.slots;
      end
      rftfc_pkg::OFF_RESP: begin
        rd_data[7:0] = state.resp;
      end
      rftfc_pkg::OFF_CRC: begin
        rd_data = {tx_crc, rx_crc};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // next state of the whole codec
  always_comb begin
    next_state         = state;
    next_state.tx_done = 1'b0;

    // apb read capture and control writes
    if (apb_setup) begin
      next_state.prdata = rd_data;
    end
    if (wr_ctrl) begin
      next_state.rx_en     = PWDATA[rftfc_pkg::CTRL_RX_EN];
      next_state.force_err = PWDATA[rftfc_pkg::CTRL_FORCE_ERR];
    end
    // write one to clear; hardware sets below win in the same cycle
    if (wr_status) begin
      if (PWDATA[rftfc_pkg::ST_FRAME_VALID]) begin
        next_state.frame_valid = 1'b0;
      end
      if (PWDATA[rftfc_pkg::ST_CRC_ERR]) begin
        next_state.crc_err = 1'b0;
      end
      if (PWDATA[rftfc_pkg::ST_CONFLICT]) begin
        next_state.conflict = 1'b0;
      end
    end

    // receive framing
    unique case (state.rx)
      rftfc_pkg::RX_IDLE: begin
        if (RX_SOF & state.rx_en) begin
          next_state.rx      = rftfc_pkg::RX_FRAME;
          next_state.bitcnt  = 3'h0;
          next_state.bytecnt = 8'h00;
          next_state.shreg   = 8'h00;
        end
      end
      rftfc_pkg::RX_FRAME: begin
        if (RX_SOF) begin
          // a fresh start of frame restarts byte alignment
          next_state.bitcnt  = 3'h0;
          next_state.bytecnt = 8'h00;
          next_state.shreg   = 8'h00;
        end else if (RX_EOF) begin
          next_state.rx = rftfc_pkg::RX_IDLE;
          // residue check over data and checksum
          if ((rx_crc == rftfc_pkg::CRC_RESIDUE) && (state.bitcnt == 3'h0) &&
              (state.bytecnt >= rftfc_pkg::MIN_FRAME_BYTES)) begin
            next_state.frame_valid = 1'b1;
          end else begin
            next_state.crc_err = 1'b1;
          end
        end else if (rx_take) begin
          next_state.shreg  = rx_byte;
          next_state.bitcnt = state.bitcnt + 3'h1;
          if (state.bitcnt == rftfc_pkg::LAST_BIT) begin
            if (state.bytecnt != rftfc_pkg::BYTES_MAX) begin
              next_state.bytecnt = state.bytecnt + 8'h01;
            end
            // first byte after start of frame is the flags field
            if (state.bytecnt == 8'h00) begin
              next_state.req = rx_byte;
              // flag bit 1 is index 0
              next_state.dec.dual_sub    = rx_byte[rftfc_pkg::FLG_SUBCARRIER];
              next_state.dec.high_rate   = rx_byte[rftfc_pkg::FLG_DATA_RATE];
              next_state.dec.inventory   = rx_byte[rftfc_pkg::FLG_INVENTORY];
              next_state.dec.extension   = rx_byte[rftfc_pkg::FLG_EXTENSION];
              next_state.dec.option      = rx_byte[rftfc_pkg::FLG_OPTION];
              next_state.dec.rich_sysinfo = 1'b0;
              // upper bits meaning follows bit 3
              if (rx_byte[rftfc_pkg::FLG_INVENTORY]) begin
                next_state.dec.afi_present   = rx_byte[rftfc_pkg::FLG_SELECT_AFI];
                next_state.dec.single_slot   = rx_byte[rftfc_pkg::FLG_ADDR_SLOTS];
                next_state.dec.slots         = rx_byte[rftfc_pkg::FLG_ADDR_SLOTS] ?
                                               rftfc_pkg::SLOTS_ONE : rftfc_pkg::SLOTS_MANY;
                next_state.dec.need_selected = 1'b0;
                next_state.dec.uid_present   = 1'b0;
              end else begin
                next_state.dec.need_selected = rx_byte[rftfc_pkg::FLG_SELECT_AFI];
                next_state.dec.uid_present   = rx_byte[rftfc_pkg::FLG_ADDR_SLOTS];
                next_state.dec.afi_present   = 1'b0;
                next_state.dec.single_slot   = 1'b0;
                next_state.dec.slots         = 5'h00;
                // reader must not combine select and addressing
                if (rx_byte[rftfc_pkg::FLG_SELECT_AFI] & rx_byte[rftfc_pkg::FLG_ADDR_SLOTS]) begin
                  next_state.conflict = 1'b1;
                end
              end
            end else if (state.bytecnt == 8'h01) begin
              next_state.cmd = rx_byte;
              next_state.dec.rich_sysinfo = state.dec.extension & (rx_byte == CMD_SYSINFO);
            end
          end
        end
      end
    endcase

    // transmit of the response flags byte
    unique case (state.tx)
      rftfc_pkg::TX_IDLE: begin
        if (tx_go) begin
          // error bit from the tag or software
          // extension and reserved bits stay zero
          next_state.resp = 8'h00;
          next_state.resp[rftfc_pkg::RSP_ERROR] = TX_ERROR | next_state.force_err;
          next_state.txsh     = next_state.resp;
          next_state.tx_bit   = TX_ERROR | next_state.force_err;
          next_state.tx_valid = 1'b1;
          next_state.txcnt    = 3'h0;
          next_state.tx       = rftfc_pkg::TX_SEND;
        end
      end
      rftfc_pkg::TX_SEND: begin
        if (tx_take) begin
          if (state.txcnt == rftfc_pkg::LAST_BIT) begin
            next_state.tx       = rftfc_pkg::TX_IDLE;
            next_state.tx_valid = 1'b0;
            next_state.tx_bit   = 1'b0;
            next_state.tx_done  = 1'b1;
          end else begin
            // next bit up goes out after the lsb
            next_state.txsh   = state.txsh >> 1;
            next_state.tx_bit = state.txsh[1];
            next_state.txcnt  = state.txcnt + 3'h1;
          end
        end
      end
    endcase
  end

  // register the whole state; receive is enabled from reset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state       <= '0;
      state.rx_en <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign PRDATA               = state.prdata;
  assign PREADY               = 1'b1;
  assign PSLVERR              = PSEL & PENABLE & ~mapped;
  assign TX_BIT               = state.tx_bit;
  assign TX_BIT_VALID         = state.tx_valid;
  assign TX_DONE              = state.tx_done;
  assign FRAME_VALID          = state.frame_valid;
  assign RESP_DUAL_SUBCARRIER = state.dec.dual_sub;
  assign RESP_HIGH_RATE       = state.dec.high_rate;
  assign NEED_SELECTED        = state.dec.need_selected;
  assign UID_PRESENT          = state.dec.uid_present;
  assign AFI_PRESENT          = state.dec.afi_present;
  assign SINGLE_SLOT          = state.dec.single_slot;
  assign RICH_SYSINFO         = state.dec.rich_sysinfo;

endmodule

`default_nettype wire

// File: pkg/rftfc_pkg.sv
// rftfc_pkg: constants, register map, flag positions and types of the flags codec
// assumes: included before the codec sources; nothing is imported, users write rftfc_pkg::name
package rftfc_pkg;

  // apb register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_REQ         = 8'h08;
  localparam logic [7:0]  OFF_DECODE      = 8'h0C;
  localparam logic [7:0]  OFF_RESP        = 8'h10;
  localparam logic [7:0]  OFF_CRC         = 8'h14;

  // flags byte width; flag bit 1 sits at index 0
  localparam int unsigned FLAGS_W         = 8;
  localparam int unsigned FLG_SUBCARRIER  = 0;
  localparam int unsigned FLG_DATA_RATE   = 1;
  localparam int unsigned FLG_INVENTORY   = 2;
  localparam int unsigned FLG_EXTENSION   = 3;
  localparam int unsigned FLG_SELECT_AFI  = 4;
  localparam int unsigned FLG_ADDR_SLOTS  = 5;
  localparam int unsigned FLG_OPTION      = 6;
  localparam int unsigned RSP_ERROR       = 0;
  localparam int unsigned RSP_EXTENSION   = 3;

  // ctrl register fields
  localparam int unsigned CTRL_RX_EN      = 0;
  localparam int unsigned CTRL_FORCE_ERR  = 1;
  localparam int unsigned CTRL_TX_GO      = 2;

  // status register fields
  localparam int unsigned ST_FRAME_VALID  = 0;
  localparam int unsigned ST_CRC_ERR      = 1;
  localparam int unsigned ST_IN_FRAME     = 2;
  localparam int unsigned ST_TX_BUSY      = 3;
  localparam int unsigned ST_CONFLICT     = 4;
  localparam int unsigned ST_BYTES_LSB    = 8;

  // decode register fields
  localparam int unsigned DEC_SLOTS_LSB   = 16;

  // crc-16 of iso/iec 13239, reflected, lsb first
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE     = 16'hF0B8;

  // slot counts and frame limits
  localparam logic [4:0]  SLOTS_MANY      = 5'h10;
  localparam logic [4:0]  SLOTS_ONE       = 5'h01;
  localparam logic [7:0]  MIN_FRAME_BYTES = 8'h04;
  localparam logic [7:0]  BYTES_MAX       = 8'hFF;
  localparam logic [2:0]  LAST_BIT        = 3'h7;
  localparam logic [7:0]  CMD_SYSINFO_DEF = 8'h2B;

  // receive and transmit states
  typedef enum logic [0:0] {
    RX_IDLE  = 1'b0,
    RX_FRAME = 1'b1
  } rftfc_rx_type;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } rftfc_tx_type;

  // decoded request flags
  typedef struct packed {
    logic       dual_sub;
    logic       high_rate;
    logic       inventory;
    logic       extension;
    logic       need_selected;
    logic       uid_present;
    logic       option;
    logic       afi_present;
    logic       single_slot;
    logic       rich_sysinfo;
    logic [4:0] slots;
  } rftfc_decode_type;

endpackage

// File: src/rftfc_crc16.sv
// rftfc_crc16: bit-serial crc-16 register, one bit per enabled cycle, lsb first
// assumes: clear and enable come from the caller's clock domain; clear wins over enable
`timescale 1ns/10ps
`default_nettype none

module rftfc_crc16 (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bit stream
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic        data_bit,
  // running value
  output logic [15:0]      crc
);

  typedef struct packed {
    logic [15:0] value;
  } rftfc_crc_state_type;

  rftfc_crc_state_type state;
  rftfc_crc_state_type next_state;
  logic                feedback;

  // next value: shift right, fold polynomial in on feedback
  always_comb begin
    next_state = state;
    feedback   = state.value[0] ^ data_bit;
    if (clear) begin
      next_state.value = rftfc_pkg::CRC_INIT;
    end else if (enable) begin
      next_state.value = (state.value >> 1) ^ (feedback ? rftfc_pkg::CRC_POLY : 16'h0000);
    end
  end

  // register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.value <= rftfc_pkg::CRC_INIT;
    end else begin
      state <= next_state;
    end
  end

  assign crc = state.value;

endmodule

`default_nettype wire

// File: tb/rftfc_codec_chk.sv
// rftfc_codec_chk: concurrent checks on the flags codec ports
// assumes: bound into rftfc_codec; rx_en stays at its reset value of 1
`timescale 1ns/10ps
`default_nettype none

module rftfc_codec_chk #(
  parameter logic [7:0] CMD_SYSINFO = 8'h2B
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // receive stream
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  // transmit stream
  input wire logic TX_START,
  input wire logic TX_ERROR,
  input wire logic TX_READY,
  input wire logic TX_BIT,
  input wire logic TX_BIT_VALID,
  input wire logic TX_DONE,
  // decoded request
  input wire logic RESP_DUAL_SUBCARRIER,
  input wire logic RESP_HIGH_RATE,
  input wire logic NEED_SELECTED,
  input wire logic UID_PRESENT,
  input wire logic AFI_PRESENT,
  input wire logic SINGLE_SLOT,
  input wire logic RICH_SYSINFO
);
  logic [4:0] rx_cnt;
  logic       rx_in;
  logic [7:0] fl;
  logic [7:0] cmd;
  logic [3:0] tx_cnt;
  wire logic  rx_take = rx_in && RX_BIT_VALID && !RX_SOF && !RX_EOF;

  // shadow of the first two frame bytes and the tx bit count
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_cnt <= 5'h00;
      rx_in  <= 1'b0;
      fl     <= 8'h00;
      cmd    <= 8'h00;
      tx_cnt <= 4'h0;
    end else begin
      if (RX_SOF) begin
        rx_in  <= 1'b1;
        rx_cnt <= 5'h00;
      end else if (RX_EOF) begin
        rx_in <= 1'b0;
      end else if (rx_take && rx_cnt < 5'h10) begin
        rx_cnt <= rx_cnt + 5'h01;
        if (rx_cnt < 5'h08) fl <= {RX_BIT, fl[7:1]};  // lsb arrives first
        else cmd <= {RX_BIT, cmd[7:1]};
      end
      if (!TX_BIT_VALID) tx_cnt <= 4'h0;
      else if (TX_READY) tx_cnt <= tx_cnt + 4'h1;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_flags_in;
    rx_take && rx_cnt == 5'h07;
  endsequence
  sequence s_cmd_in;
    rx_take && rx_cnt == 5'h0F;
  endsequence
  sequence s_last_bit;
    TX_BIT_VALID && TX_READY && tx_cnt == 4'h7;
  endsequence

  AST_SUBCARRIER:
    assert property (s_flags_in |=> RESP_DUAL_SUBCARRIER == fl[0]) else $error("subcarrier pin wrong");
  AST_RATE:
    assert property (s_flags_in |=> RESP_HIGH_RATE == fl[1]) else $error("rate pin wrong");
  AST_SELECT:
    assert property (s_flags_in |=> NEED_SELECTED == (!fl[2] && fl[4]) && UID_PRESENT == (!fl[2] && fl[5]))
      else $error("selection pins wrong");
  AST_INVENTORY:
    assert property (s_flags_in |=> AFI_PRESENT == (fl[2] && fl[4]) && SINGLE_SLOT == (fl[2] && fl[5]))
      else $error("inventory pins wrong");
  AST_RICH:
    assert property (s_cmd_in |=> RICH_SYSINFO == (fl[3] && cmd == CMD_SYSINFO)) else $error("sysinfo pin wrong");
  AST_ERR_BIT:
    assert property (TX_START && !TX_BIT_VALID && TX_ERROR |=> TX_BIT_VALID && TX_BIT) else $error("error bit lost");
  AST_RSV_ZERO:
    assert property (TX_BIT_VALID && tx_cnt != 4'h0 |-> !TX_BIT) else $error("reserved bit set");
  AST_LAST:
    assert property (s_last_bit |=> TX_DONE && !TX_BIT_VALID ##1 !TX_DONE) else $error("done not after bit 8");
  AST_HOLD:
    assert property (TX_BIT_VALID && !TX_READY |=> TX_BIT_VALID && $stable(TX_BIT)) else $error("tx bit moved");
endmodule

bind rftfc_codec rftfc_codec_chk #(.CMD_SYSINFO(CMD_SYSINFO)) i_chk (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .RX_SOF(RX_SOF), .RX_EOF(RX_EOF), .RX_BIT_VALID(RX_BIT_VALID),
  .RX_BIT(RX_BIT), .TX_START(TX_START), .TX_ERROR(TX_ERROR), .TX_READY(TX_READY), .TX_BIT(TX_BIT),
  .TX_BIT_VALID(TX_BIT_VALID), .TX_DONE(TX_DONE), .RESP_DUAL_SUBCARRIER(RESP_DUAL_SUBCARRIER),
  .RESP_HIGH_RATE(RESP_HIGH_RATE), .NEED_SELECTED(NEED_SELECTED), .UID_PRESENT(UID_PRESENT),
  .AFI_PRESENT(AFI_PRESENT), .SINGLE_SLOT(SINGLE_SLOT), .RICH_SYSINFO(RICH_SYSINFO));
`default_nettype wire

// File: tb/rftfc_reader.sv
// rftfc_reader: reader model sending request frames and pacing the answer
// assumes: tasks are called by the bench right after a rising clock edge
`timescale 1ns/10ps
`default_nettype none

module rftfc_reader #(
  parameter logic [7:0] BLOCK_CMD = 8'h20
) (
  // clock
  input  wire logic clk,
  // request stream
  output logic      sof,
  output logic      eof,
  output logic      bit_valid,
  output logic      bit_val,
  // answer pacing
  input  wire logic slow,
  output logic      tx_ready
);
  logic [15:0] crc;
  logic [31:0] r;
  int          seed = 88197;

  initial sof = 1'b0;
  initial eof = 1'b0;
  initial bit_valid = 1'b0;
  initial bit_val = 1'b0;
  initial tx_ready = 1'b1;

  // random stalls only when asked, else always ready
  always @(posedge clk) begin
    r = $random(seed);
    tx_ready <= !slow || r[0];
  end

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      bit_valid <= 1'b1;
      bit_val   <= b[i];
      crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? rftfc_pkg::CRC_POLY : 16'h0000);
    end
  endtask

  // whole frame: sof, flags, command, checksum, eof
  task automatic send_frame(input logic [7:0] flags, input logic [7:0] cmd, input logic bad,
                            input logic misuse, output logic [7:0] used);
    logic [15:0] c;
    used = flags;
    if (cmd == BLOCK_CMD) used[3] = 1'b1;
    // select clears addressing, unless misuse is commanded
    if (!misuse && !used[2] && used[4]) used[5] = 1'b0;
    @(posedge clk);
    sof <= 1'b1;
    crc = rftfc_pkg::CRC_INIT;
    @(posedge clk);
    sof <= 1'b0;
    send_byte(used);
    send_byte(cmd);
    c = ~crc ^ {15'h0000, bad};
    send_byte(c[7:0]);
    send_byte(c[15:8]);
    @(posedge clk);
    bit_valid <= 1'b0;
    bit_val   <= ~bit_val;  // released line must not keep its value
    eof       <= 1'b1;
    @(posedge clk);
    eof <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/rftfc_codec_test.sv
// rftfc_codec_test: self-checking bench for the flags codec
// assumes: reader model drives the rx stream and tx pacing; apb master here
`timescale 1ns/10ps
`default_nettype none

module rftfc_codec_test;
  logic        REF_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, RX_SOF, RX_EOF, RX_BIT_VALID, RX_BIT, TX_READY, TX_BIT, TX_BIT_VALID, TX_DONE;
  logic        TX_START = 1'b0, TX_ERROR = 1'b0, slow = 1'b0;
  logic        FRAME_VALID, RESP_DUAL_SUBCARRIER, RESP_HIGH_RATE, NEED_SELECTED;
  logic        UID_PRESENT, AFI_PRESENT, SINGLE_SLOT, RICH_SYSINFO;
  logic [7:0]  tx_sh;
  int          n_errors = 0, n_tests = 0, n_done = 0, seed = 88197;
  int          exp_q[$];

  always #5 REF_CLK = ~REF_CLK;

  rftfc_codec i_dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_SOF(RX_SOF),
    .RX_EOF(RX_EOF), .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT(RX_BIT), .TX_START(TX_START), .TX_ERROR(TX_ERROR),
    .TX_READY(TX_READY), .TX_BIT(TX_BIT), .TX_BIT_VALID(TX_BIT_VALID), .TX_DONE(TX_DONE),
    .FRAME_VALID(FRAME_VALID), .RESP_DUAL_SUBCARRIER(RESP_DUAL_SUBCARRIER), .RESP_HIGH_RATE(RESP_HIGH_RATE),
    .NEED_SELECTED(NEED_SELECTED), .UID_PRESENT(UID_PRESENT), .AFI_PRESENT(AFI_PRESENT),
    .SINGLE_SLOT(SINGLE_SLOT), .RICH_SYSINFO(RICH_SYSINFO));

  rftfc_reader i_rdr (.clk(REF_CLK), .sof(RX_SOF), .eof(RX_EOF), .bit_valid(RX_BIT_VALID), .bit_val(RX_BIT),
    .slow(slow), .tx_ready(TX_READY));

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input string w, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask

  task automatic chk_byte(input string w, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      close_out();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk_word(w, x, q);
  endtask

  // expected decode word from the flags and command byte
  function automatic int exp_decode(input int f, input int c);
    int d;
    d = (f & 15) + (((f >> 6) & 1) << 6);
    if ((f >> 2) & 1) d += (((f >> 4) & 1) << 7) + (((f >> 5) & 1) << 8) + ((((f >> 5) & 1) ? 1 : 16) << 16);
    else d += (((f >> 4) & 1) << 4) + (((f >> 5) & 1) << 5);
    if (((f >> 3) & 1) && c == rftfc_pkg::CMD_SYSINFO_DEF) d += 1 << 9;
    return d;
  endfunction

  // collect the answer byte and compare at done
  always @(posedge REF_CLK) begin
    if (TX_BIT_VALID && TX_READY) tx_sh <= {TX_BIT, tx_sh[7:1]};
    if (TX_DONE === 1'b1) begin
      n_done++;
      if (exp_q.size() > 0) chk_byte("tx byte", exp_q.pop_front(), tx_sh);
    end
  end

  initial begin
    logic [31:0] q;
    logic        e, cf;
    logic [7:0]  cmd, used;
    int          d, prev, n;
    repeat (20) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    rd_chk("ctrl", rftfc_pkg::OFF_CTRL, 32'h00000001);
    rd_chk("decode", rftfc_pkg::OFF_DECODE, 32'h00000000);
    rd_chk("crc", rftfc_pkg::OFF_CRC, 32'hFFFFFFFF);
    apb(1'b0, 8'h1A, 32'h0, q, e);
    chk_word("unmapped", 32'h00000001, {q[30:0], e});
    $display("test reset done");
    // every flags code, system info command on every third code, random commands otherwise; some codes break the select rule on purpose
    for (int i = 0; i < 256; i++) begin
      cmd = (i % 3 == 0) ? rftfc_pkg::CMD_SYSINFO_DEF : 8'($random(seed));
      i_rdr.send_frame(i[7:0], cmd, 1'b0, i[6], used);
      d = exp_decode(used, cmd);
      cf = !used[2] && used[4] && used[5];
      rd_chk("decode", rftfc_pkg::OFF_DECODE, d);
      chk_byte("pins", {1'b1, d[9], d[8], d[7], d[5], d[4], d[1], d[0]}, {FRAME_VALID, RICH_SYSINFO, SINGLE_SLOT,
        AFI_PRESENT, UID_PRESENT, NEED_SELECTED, RESP_HIGH_RATE, RESP_DUAL_SUBCARRIER});
      rd_chk("req", rftfc_pkg::OFF_REQ, {16'h0, cmd, used});
      rd_chk("status", rftfc_pkg::OFF_STATUS, 32'h00000401 | {27'h0, cf, 4'h0});
      apb(1'b1, rftfc_pkg::OFF_STATUS, 32'h00000013, q, e);
    end
    $display("test flags done");
    i_rdr.send_frame(8'h01, 8'h2B, 1'b1, 1'b0, used);
    rd_chk("status", rftfc_pkg::OFF_STATUS, 32'h00000402);
    chk_byte("frame pin", 8'h00, {7'h00, FRAME_VALID});
    apb(1'b1, rftfc_pkg::OFF_STATUS, 32'h00000013, q, e);
    $display("test bad checksum done");
    // answers: pin start with and without error, register start with forced error
    for (int k = 0; k < 4; k++) begin
      prev = n_done;
      slow <= k[1];
      if (k == 3) begin
        exp_q.push_back(1);
        apb(1'b1, rftfc_pkg::OFF_CTRL, 32'h00000007, q, e);
      end else begin
        exp_q.push_back(k % 2);
        @(posedge REF_CLK);
        TX_START <= 1'b1;
        TX_ERROR <= k[0];
        @(posedge REF_CLK);
        TX_START <= 1'b0;
      end
      n = 0;
      while (n_done == prev && n < 300) begin
        @(posedge REF_CLK);
        n++;
      end
      if (n >= 300) begin
        n_errors++;
        close_out();
      end
    end
    rd_chk("resp", rftfc_pkg::OFF_RESP, 32'h00000001);
    apb(1'b1, rftfc_pkg::OFF_CTRL, 32'h00000001, q, e);
    $display("test answer done");
    close_out();
  end
endmodule
`default_nettype wire
